// [design/vpt_bridge.sv]
// Inbound VME-to-PCI page translation with host-programmed mapping table
`timescale 1ns/1ps
// Operation
// - Jumpered aperture, anywhere, at most 16M bytes
// - Table of 4096 entries, one per page
// - Entries sit at window offsets 8000 to BFFF
// - Full VME address arrives over the cable
// - Address bits 11..2 pass through unchanged
// - Address bits 23..12 select the entry
// - Entry gives upper address and swap controls
// - Entry bits 31..12 are the page base
// - Access performed, read data returned to master
// - Invalid bit set gives a bus error
// - Bit 1 swaps bytes of word/long transfers
// - Bit 2 inverts A1 on word transfers
// - Bit 3 swaps single-byte transfers
// - Bits 11..4 reserved, no translation effect
// - Entry n at table offset four times n
// - Window base at config offset 18, decoded
module vpt_bridge (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Aperture jumpers
    input wire logic [31:0] aper_base,
    input wire logic [12:0] aper_pages,
    // Configuration space access
    input wire logic cfg_req,
    input wire logic cfg_we,
    input wire logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack_q,
    output logic [31:0] cfg_rdata_q,
    // Mapping window memory target
    input wire logic host_req,
    input wire logic host_we,
    input wire logic [31:0] host_addr,
    input wire logic [31:0] host_wdata,
    output logic host_ack_q,
    output logic [31:0] host_rdata_q,
    // Cable request from the VME card
    input wire logic cab_req,
    input vpt_pkg::vpt_vme_req_s cab_cmd,
    output logic cab_done_q,
    output logic cab_berr_q,
    output logic [31:0] cab_rdata_q,
    // PCI memory master
    output logic pm_req_q,
    output vpt_pkg::vpt_pci_req_s pm_cmd_q,
    input wire logic pm_ack,
    input wire logic pm_err,
    input wire logic [31:0] pm_rdata
);
    import vpt_pkg::*;

    function automatic logic is_entry(input logic [WIN_BITS-1:0] off);
        return off >= OFF_MAP_LO && off <= OFF_MAP_HI;
    endfunction : is_entry

    function automatic logic [31:0] ent_word(input vpt_entry_s e);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[31:ENT_PAGE_LSB] = e.page;
        w[ENT_SWAPB_BIT] = e.swap_byte;
        w[ENT_WSWAP_BIT] = e.word_swap;
        w[ENT_SWAPNB_BIT] = e.swap_nonbyte;
        w[ENT_INVALID_BIT] = e.invalid;
        return w;
    endfunction : ent_word

    vpt_state_e state_q;
    vpt_vme_req_s req_q;
    vpt_entry_s ent_q;
    vpt_entry_s ram_q;
    vpt_entry_s ram_wdata;
    vpt_entry_s sw_ent;
    logic [BASE_W-1:0] base_q;
    logic [WIN_BITS-1:0] host_off;
    logic host_hit;
    logic host_take;
    logic host_ent;
    logic vme_take;
    logic in_win;
    logic [31:0] aper_off;
    logic [12:0] pages;
    logic ram_en;
    logic ram_we;
    logic [IDX_BITS-1:0] ram_addr;
    logic [1:0] sw_lo;
    logic [3:0] sw_be;
    logic [31:0] sw_wdata;
    logic [31:0] sw_rdata;

    // Host decode of the mapping window
    assign host_off = host_addr[WIN_BITS-1:0];
    assign host_hit = host_addr[31:WIN_BITS] == base_q;
    assign host_ent = is_entry(host_off);
    assign host_take = state_q == ST_IDLE && host_req && !host_ack_q
        && host_hit;

    // Aperture test works on the absolute address from the cable
    assign pages = aper_pages > APER_MAX_PAGES ? APER_MAX_PAGES : aper_pages;
    assign aper_off = cab_cmd.addr - aper_base;
    assign in_win = aper_off[31:PAGE_BITS] < {7'h00, pages};
    // Host access wins a tie: table maintenance must not starve
    assign vme_take = state_q == ST_IDLE && !host_take && cab_req
        && !cab_done_q && in_win;

    // Single table port shared by host access and lookups
    assign ram_en = (host_take && host_ent) || vme_take;
    assign ram_we = host_take && host_we;
    // Index is absolute bits 23..12, not an offset into the aperture
    assign ram_addr = host_take ? host_off[IDX_BITS+1:2]
        : cab_cmd.addr[23:PAGE_BITS];
    always_comb begin
        ram_wdata.page = host_wdata[31:ENT_PAGE_LSB];
        ram_wdata.swap_byte = host_wdata[ENT_SWAPB_BIT];
        ram_wdata.word_swap = host_wdata[ENT_WSWAP_BIT];
        ram_wdata.swap_nonbyte = host_wdata[ENT_SWAPNB_BIT];
        ram_wdata.invalid = host_wdata[ENT_INVALID_BIT];
    end

    vpt_map_ram #(
        .DEPTH(ENTRIES),
        .AW(IDX_BITS),
        .DW(ENT_W)
    ) u_ram (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .en(ram_en),
        .we(ram_we),
        .addr(ram_addr),
        .wdata(ram_wdata),
        .rdata_q(ram_q)
    );

    // Fresh table word during lookup, latched copy while on PCI
    assign sw_ent = state_q == ST_LOOK ? ram_q : ent_q;

    vpt_swap u_swap (
        .ent(sw_ent),
        .size(req_q.size),
        .addr_lo(req_q.addr[1:0]),
        .wdata(req_q.wdata),
        .lane_rdata(pm_rdata),
        .out_lo(sw_lo),
        .be(sw_be),
        .lane_wdata(sw_wdata),
        .rdata(sw_rdata)
    );

    // Sequencer
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (host_take) begin
                        state_q <= (!host_we && host_ent) ? ST_HREAD : ST_IDLE;
                    end else if (vme_take) begin
                        state_q <= ST_LOOK;
                    end
                end
                ST_HREAD: state_q <= ST_IDLE;
                ST_LOOK: state_q <= ram_q.invalid ? ST_IDLE : ST_PCI;
                ST_PCI: begin
                    if (pm_ack) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Cable request is captured whole, then translated
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_q <= '0;
        end else if (vme_take) begin
            req_q <= cab_cmd;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ent_q <= '0;
        end else if (state_q == ST_LOOK) begin
            ent_q <= ram_q;
        end
    end

    // PCI master request
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pm_req_q <= 1'b0;
            pm_cmd_q <= '0;
        end else if (state_q == ST_LOOK && !ram_q.invalid) begin
            pm_req_q <= 1'b1;
            pm_cmd_q.addr <= {ram_q.page,
                req_q.addr[PAGE_BITS-1:2], sw_lo};
            pm_cmd_q.wr <= req_q.wr;
            pm_cmd_q.be <= sw_be;
            pm_cmd_q.wdata <= sw_wdata;
        end else if (state_q == ST_PCI && pm_ack) begin
            pm_req_q <= 1'b0;
        end
    end

    // Answer to the cable
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cab_done_q <= 1'b0;
            cab_berr_q <= 1'b0;
            cab_rdata_q <= 32'h0000_0000;
        end else begin
            cab_done_q <= 1'b0;
            if (state_q == ST_LOOK && ram_q.invalid) begin
                cab_done_q <= 1'b1;
                cab_berr_q <= 1'b1;
                cab_rdata_q <= 32'h0000_0000;
            end else if (state_q == ST_PCI && pm_ack) begin
                cab_done_q <= 1'b1;
                cab_berr_q <= pm_err;
                cab_rdata_q <= (pm_err || req_q.wr) ? 32'h0000_0000
                    : sw_rdata;
            end
        end
    end

    // Host target answers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            host_ack_q <= 1'b0;
            host_rdata_q <= 32'h0000_0000;
        end else begin
            host_ack_q <= 1'b0;
            if (host_take && (host_we || !host_ent)) begin
                // Other tables and memory of the window are not here
                host_ack_q <= 1'b1;
                host_rdata_q <= RD_DEFAULT;
            end else if (state_q == ST_HREAD) begin
                host_ack_q <= 1'b1;
                host_rdata_q <= ent_word(ram_q);
            end
        end
    end

    // Configuration register holding the window base
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            base_q <= '0;
            cfg_ack_q <= 1'b0;
            cfg_rdata_q <= 32'h0000_0000;
        end else begin
            cfg_ack_q <= cfg_req && !cfg_ack_q;
            if (cfg_req && !cfg_ack_q) begin
                if (cfg_we && cfg_addr == CFG_MAPWIN_OFF) begin
                    base_q <= cfg_wdata[31:WIN_BITS];
                end
                if (!cfg_we) begin
                    cfg_rdata_q <= cfg_addr == CFG_MAPWIN_OFF
                        ? {base_q, {WIN_BITS{1'b0}}} : RD_DEFAULT;
                end
            end
        end
    end

    // A misplaced aperture still works; only the entry order shifts

    a_out_window: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_q == ST_IDLE && cab_req && !in_win && !host_take
        |=> state_q == ST_IDLE)
        else $error("request outside aperture was taken");

    a_entry_index: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        vme_take |-> ram_en && !ram_we
        && ram_addr == cab_cmd.addr[23:12])
        else $error("lookup used wrong entry index");

    a_table_write: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        host_take && host_we && host_ent |-> ram_en && ram_we
        && ram_addr == host_off[13:2])
        else $error("table write not at entry of offset");

    a_low_bits: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        pm_req_q |-> pm_cmd_q.addr[11:2] == req_q.addr[11:2])
        else $error("low address bits altered");

    a_page_base: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_q == ST_LOOK && !ram_q.invalid
        |=> pm_req_q && pm_cmd_q.addr[31:12] == $past(ram_q.page))
        else $error("page base not applied");

    a_invalid_err: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_q == ST_LOOK && ram_q.invalid
        |=> cab_done_q && cab_berr_q && !pm_req_q)
        else $error("invalid entry did not give bus error");

    a_word_swap: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_q == ST_LOOK && !ram_q.invalid && ram_q.word_swap
        && req_q.size == SZ_WORD
        |=> pm_cmd_q.addr[1] != req_q.addr[1])
        else $error("word swap did not invert A1");

    a_hold_pending: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        pm_req_q && !pm_ack |=> pm_req_q && $stable(pm_cmd_q)
        && !cab_done_q)
        else $error("PCI request dropped before completion");

    a_read_return: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_q == ST_PCI && pm_ack && !pm_err && !req_q.wr
        |=> cab_done_q && !cab_berr_q
        && cab_rdata_q == $past(sw_rdata))
        else $error("read data not returned");

    a_done_pulse: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        cab_done_q |=> !cab_done_q && !pm_req_q)
        else $error("done longer than one cycle");

    a_reserved_zero: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        host_ack_q |-> host_rdata_q[11:4] == 8'h00)
        else $error("reserved bits read nonzero");

    a_base_decode: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        cfg_req && !cfg_ack_q && cfg_we && cfg_addr == CFG_MAPWIN_OFF
        |=> base_q == $past(cfg_wdata[31:18]))
        else $error("window base not written");

    a_lookup_start: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        vme_take |=> state_q == ST_LOOK
        && req_q == $past(cab_cmd))
        else $error("cable request not captured whole");

    a_long_swap: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_q == ST_LOOK && !ram_q.invalid && ram_q.swap_nonbyte
        && req_q.size == SZ_LONG |=> pm_cmd_q.wdata == {req_q.wdata[7:0],
        req_q.wdata[15:8], req_q.wdata[23:16], req_q.wdata[31:24]})
        else $error("long data bytes not reversed");

endmodule : vpt_bridge

// [pkg/vpt_pkg.sv]
// Shared constants, types and carriers for the VME-to-PCI page translator
package vpt_pkg;

    // Page and table geometry
    localparam int unsigned PAGE_BITS = 12;
    localparam int unsigned IDX_BITS = 12;
    localparam int unsigned ENTRIES = 4096;
    localparam logic [12:0] APER_MAX_PAGES = 13'h1000;

    // Host-visible mapping window
    localparam int unsigned WIN_BITS = 18;
    localparam int unsigned BASE_W = 32 - WIN_BITS;
    localparam logic [17:0] OFF_MAP_LO = 18'h08000;
    localparam logic [17:0] OFF_MAP_HI = 18'h0bfff;
    localparam logic [7:0] CFG_MAPWIN_OFF = 8'h18;
    localparam logic [31:0] RD_DEFAULT = 32'h0000_0000;

    // Entry field positions
    localparam int unsigned ENT_INVALID_BIT = 0;
    localparam int unsigned ENT_SWAPNB_BIT = 1;
    localparam int unsigned ENT_WSWAP_BIT = 2;
    localparam int unsigned ENT_SWAPB_BIT = 3;
    localparam int unsigned ENT_PAGE_LSB = 12;
    localparam int unsigned ENT_W = 24;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_WORD = 2'h1,
        SZ_LONG = 2'h2
    } vpt_size_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_LOOK = 3'h1,
        ST_PCI = 3'h3,
        ST_HREAD = 3'h4
    } vpt_state_e;

    // Stored entry; reserved bits are not kept
    typedef struct packed {
        logic [19:0] page;
        logic swap_byte;
        logic word_swap;
        logic swap_nonbyte;
        logic invalid;
    } vpt_entry_s;

    // Request arriving over the cable, data right-justified
    typedef struct packed {
        logic [31:0] addr;
        logic wr;
        vpt_size_e size;
        logic [31:0] wdata;
    } vpt_vme_req_s;

    // Translated PCI memory request, data on byte lanes
    typedef struct packed {
        logic [31:0] addr;
        logic wr;
        logic [3:0] be;
        logic [31:0] wdata;
    } vpt_pci_req_s;

endpackage : vpt_pkg

// [design/vpt_map_ram.sv]
// Page mapping table storage with registered read data
`timescale 1ns/1ps
module vpt_map_ram #(
    parameter int unsigned DEPTH = 4096,
    parameter int unsigned AW = 12,
    parameter int unsigned DW = 24
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Access port
    input wire logic en,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata_q
);

    // No reset on the array: contents are undefined until software fills it
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= '0;
        end else if (en && !we) begin
            rdata_q <= mem[addr];
        end
    end

endmodule : vpt_map_ram

// [design/vpt_swap.sv]
// Byte and word swap steering between cable data and PCI byte lanes
`timescale 1ns/1ps
module vpt_swap (
    // Entry controls and transfer shape
    input vpt_pkg::vpt_entry_s ent,
    input vpt_pkg::vpt_size_e size,
    input wire logic [1:0] addr_lo,
    // Data
    input wire logic [31:0] wdata,
    input wire logic [31:0] lane_rdata,
    output logic [1:0] out_lo,
    output logic [3:0] be,
    output logic [31:0] lane_wdata,
    output logic [31:0] rdata
);
    import vpt_pkg::*;

    function automatic logic [31:0] order(input logic [31:0] v,
                                          input vpt_size_e sz,
                                          input logic rev);
        logic [31:0] r;
        r = v;
        if (sz == SZ_BYTE) begin
            r = {24'h000000, v[7:0]};
        end else if (sz == SZ_WORD) begin
            r = rev ? {16'h0000, v[7:0], v[15:8]} : {16'h0000, v[15:0]};
        end else if (rev) begin
            r = {v[7:0], v[15:8], v[23:16], v[31:24]};
        end
        return r;
    endfunction : order

    logic rev;
    logic [4:0] sh;

    always_comb begin
        out_lo[1] = addr_lo[1] ^ (ent.word_swap && size == SZ_WORD);
        out_lo[0] = addr_lo[0] ^ (ent.swap_byte && size == SZ_BYTE);
        rev = ent.swap_nonbyte && size != SZ_BYTE;
        sh = 5'h00;
        be = 4'hf;
        if (size == SZ_BYTE) begin
            sh = {out_lo, 3'h0};
            be = 4'(4'h1 << out_lo);
        end else if (size == SZ_WORD) begin
            sh = {out_lo[1], 4'h0};
            be = out_lo[1] ? 4'hc : 4'h3;
        end
        lane_wdata = order(wdata, size, rev) << sh;
        rdata = order(lane_rdata >> sh, size, rev);
    end

endmodule : vpt_swap

// [sim/vpt_pci_mem.sv]
// Behavioural PCI memory target answering the bridge's master port
`timescale 1ns/1ps
module vpt_pci_mem #(
    parameter logic [31:0] PAT = 32'h5a3c_96e1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Master port of the bridge
    input wire logic pm_req_q,
    input vpt_pkg::vpt_pci_req_s pm_cmd_q,
    output logic pm_ack,
    output logic pm_err,
    output logic [31:0] pm_rdata,
    // Bench controls and record of the last access
    input wire logic [3:0] delay,
    input wire logic err_en,
    output vpt_pkg::vpt_pci_req_s last_cmd,
    output logic [15:0] n_acc
);
    import vpt_pkg::*;
    logic [3:0] cnt;

    // Read data is a pattern of the word address; between answers the
    // lanes toggle so a stale value is never mistaken for a fresh one
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pm_ack <= 1'b0;
            pm_err <= 1'b0;
            pm_rdata <= 32'h0f0f_a5a5;
            cnt <= 4'h0;
            n_acc <= 16'h0;
            last_cmd <= '0;
        end else if (pm_ack) begin
            pm_ack <= 1'b0;
            pm_err <= 1'b0;
            pm_rdata <= ~pm_rdata;
            cnt <= 4'h0;
        end else if (pm_req_q && cnt == delay) begin
            pm_ack <= 1'b1;
            pm_err <= err_en;
            pm_rdata <= {pm_cmd_q.addr[31:2], 2'b00} ^ PAT;
            last_cmd <= pm_cmd_q;
            n_acc <= n_acc + 16'h1;
        end else begin
            pm_rdata <= ~pm_rdata;
            if (pm_req_q) begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule : vpt_pci_mem

// [sim/vpt_bridge_bench.sv]
// Self-checking bench for the VME-to-PCI page translator
`timescale 1ns/1ps
module vpt_bridge_bench;
    import vpt_pkg::*;
    localparam logic [31:0] WBASE = 32'h8200_0000;
    localparam logic [31:0] PAT = 32'h5a3c_96e1;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [31:0] aper_base = 32'h8040_0000;
    logic [12:0] aper_pages = 13'h1000;
    logic cfg_req = 1'b0;
    logic cfg_we = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [31:0] cfg_wdata = 32'h0;
    logic host_req = 1'b0;
    logic host_we = 1'b0;
    logic [31:0] host_addr = 32'h0;
    logic [31:0] host_wdata = 32'h0;
    logic cab_req = 1'b0;
    vpt_vme_req_s cab_cmd = '0;
    logic [3:0] dly = 4'h0;
    logic perr = 1'b0;
    logic cfg_ack_q, host_ack_q, cab_done_q, cab_berr_q, pm_req_q;
    logic pm_ack, pm_err;
    logic [31:0] cfg_rdata_q, host_rdata_q, cab_rdata_q, pm_rdata;
    vpt_pci_req_s pm_cmd_q, last_cmd;
    logic [15:0] n_acc;
    logic [31:0] seed = 32'd80721;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    vpt_bridge uut (.ref_clk(ref_clk), .reset_n(reset_n),
        .aper_base(aper_base), .aper_pages(aper_pages),
        .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_ack_q(cfg_ack_q),
        .cfg_rdata_q(cfg_rdata_q), .host_req(host_req),
        .host_we(host_we), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_ack_q(host_ack_q),
        .host_rdata_q(host_rdata_q), .cab_req(cab_req),
        .cab_cmd(cab_cmd), .cab_done_q(cab_done_q),
        .cab_berr_q(cab_berr_q), .cab_rdata_q(cab_rdata_q),
        .pm_req_q(pm_req_q), .pm_cmd_q(pm_cmd_q), .pm_ack(pm_ack),
        .pm_err(pm_err), .pm_rdata(pm_rdata));

    vpt_pci_mem #(.PAT(PAT)) mem (.ref_clk(ref_clk), .reset_n(reset_n),
        .pm_req_q(pm_req_q), .pm_cmd_q(pm_cmd_q), .pm_ack(pm_ack),
        .pm_err(pm_err), .pm_rdata(pm_rdata), .delay(dly),
        .err_en(perr), .last_cmd(last_cmd), .n_acc(n_acc));

    always #25 ref_clk = ~ref_clk;

    // A hung handshake is cut short well past the expected run length
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [31:0] sw(input vpt_size_e s,
                                       input logic [31:0] d);
        return s == SZ_WORD ? {16'h0, d[7:0], d[15:8]}
                            : {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction : sw

    // One config (h=0) or mapping window (h=1) access, held until acked
    task automatic acc(input bit h, input logic we, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        @(negedge ref_clk);
        if (h) begin
            host_req = 1'b1;
            host_we = we;
            host_addr = a;
            host_wdata = d;
        end else begin
            cfg_req = 1'b1;
            cfg_we = we;
            cfg_addr = a[7:0];
            cfg_wdata = d;
        end
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while ((h ? host_ack_q : cfg_ack_q) !== 1'b1 && n < 40);
        q = h ? host_rdata_q : cfg_rdata_q;
        host_req = 1'b0;
        cfg_req = 1'b0;
        check("ack", n < 40, 1);
    endtask : acc

    task automatic vme(input logic [31:0] a, input logic wr,
                       input vpt_size_e sz, input logic [31:0] d,
                       input int lim, output bit got);
        int n;
        @(negedge ref_clk);
        cab_req = 1'b1;
        cab_cmd = '{addr: a, wr: wr, size: sz, wdata: d};
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (cab_done_q !== 1'b1 && n < lim);
        got = cab_done_q === 1'b1;
        cab_req = 1'b0;
    endtask : vme

    // Program the entry that address a selects, then translate one access
    task automatic run(input logic [31:0] a, input logic [31:0] e,
                       input logic wr, input vpt_size_e sz,
                       input logic [31:0] d);
        logic [31:0] q, wa, pa, wl, rr, v;
        logic [1:0] lo;
        logic [3:0] be;
        logic [15:0] na;
        logic nb;
        bit got;
        wa = WBASE + 32'h8000 + {a[23:12], 2'b00};
        acc(1, 1, wa, e, q);
        acc(1, 0, wa, 0, q);
        check("entry", q, {e[31:12], 8'h00, e[3:0]});
        nb = sz != SZ_BYTE;
        lo = {a[1] ^ (e[2] && sz == SZ_WORD), a[0] ^ (e[3] && !nb)};
        pa = {e[31:12], a[11:2], lo};
        be = !nb ? 4'h1 << lo : sz == SZ_WORD ? (lo[1] ? 4'hc : 4'h3) : 4'hf;
        v = e[1] && nb ? sw(sz, d) : d;
        wl = !nb ? v << 8 * lo : sz == SZ_WORD ? v << 16 * lo[1] : v;
        rr = {pa[31:2], 2'b00} ^ PAT;
        rr = !nb ? (rr >> 8 * lo) & 32'hff
           : sz == SZ_WORD ? (rr >> 16 * lo[1]) & 32'hffff : rr;
        if (e[1] && nb) rr = sw(sz, rr);
        if (wr || perr) rr = 32'h0;
        na = n_acc;
        vme(a, wr, sz, d, 40, got);
        check("done", got, 1);
        check("berr", cab_berr_q, e[0] | perr);
        check("accesses", n_acc, na + 16'(!e[0]));
        if (!e[0]) begin
            check("pci addr", last_cmd.addr, pa);
            check("enables", last_cmd.be, be);
            check("direction", last_cmd.wr, wr);
            if (wr) check("lanes", last_cmd.wdata, wl);
            check("read data", cab_rdata_q, rr);
        end
    endtask : run

    initial begin
        logic [31:0] q, r, a, e, d;
        vpt_size_e sz;
        bit got;
        repeat (16) @(negedge ref_clk);
        reset_n = 1'b1;
        @(negedge ref_clk);
        check("idle", {cfg_ack_q, host_ack_q, cab_done_q, pm_req_q}, 0);
        acc(0, 1, 32'h18, WBASE | 32'h1234, q);
        acc(0, 0, 32'h18, 0, q);
        check("window base", q, WBASE);
        acc(0, 0, 32'h1c, 0, q);
        check("other config", q, 0);
        acc(1, 1, WBASE + 32'h7ffc, 32'hffff_ffff, q);
        acc(1, 0, WBASE + 32'h7ffc, 0, q);
        check("below table", q, 0);
        acc(1, 1, WBASE + 32'hc000, 32'hffff_ffff, q);
        acc(1, 0, WBASE + 32'hc000, 0, q);
        check("above table", q, 0);
        // First pass hits entry 400h, second the last entry of the table
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            sz = vpt_size_e'(r[1:0] % 2'd3);
            a = aper_base + (i == 0 ? 32'h0 : i == 1 ? 32'hbffffc
                             : rnd() & 32'hff_ffff);
            if (sz == SZ_WORD) a[0] = 1'b0;
            if (sz == SZ_LONG) a[1:0] = 2'b00;
            e = rnd();
            e[0] = r[4:2] == 3'h0;
            d = rnd() & (sz == SZ_BYTE ? 32'hff
                         : sz == SZ_WORD ? 32'hffff : 32'hffff_ffff);
            dly = {1'b0, r[7:5]};
            perr = r[10:8] == 3'h0;
            run(a, e, r[11], sz, d);
        end
        perr = 1'b0;
        dly = 4'h0;
        aper_pages = 13'h5;
        vme(aper_base + 32'h5000, 1'b0, SZ_LONG, 0, 12, got);
        check("outside aperture", got, 0);
        run(aper_base + 32'h4ffc, 32'h1234_5000, 1'b0, SZ_LONG, 0);
        aper_base = 32'h8100_0000;
        run(aper_base, 32'h0abc_d002, 1'b1, SZ_LONG, 32'h1122_3344);
        stop_test();
    end
endmodule : vpt_bridge_bench
